/* hw/sbat_pin_sync.sv */
// Three-stage synchroniser for pin inputs with a stability check on stages two and three.
`timescale 1ns/1ps
`default_nettype none
module sbat_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output var  logic [WIDTH-1:0] stable
);
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic s1;
        logic s2;
        logic s3;
        always_ff @(posedge clock or negedge reset_n) begin
            if (!reset_n) begin
                s1        <= 1'b0;
                s2        <= 1'b0;
                s3        <= 1'b0;
                stable[i] <= 1'b0;
            end else begin
                s1 <= pin[i];
                s2 <= s1;
                s3 <= s2;
                if (s2 == s3) begin
                    stable[i] <= s3;
                end
            end
        end
    end
endmodule : sbat_pin_sync
`default_nettype wire

/* hw/sbat_pkg.sv */
// Constants shared by the system bus address tenure logic.
package sbat_pkg;
    localparam int          ADDR_W        = 32;
    localparam int          TYPE_W        = 5;
    localparam int          SIZE_W        = 4;
    localparam int          CS_COUNT      = 8;
    localparam int          CS_SEL_W      = 3;
    localparam int          CS_SEL_LSB    = 29;
    localparam int          BEAT_W        = 5;
    localparam int          SYNC_STAGES   = 3;
    localparam int          PIN_W         = ADDR_W + TYPE_W + SIZE_W + 3;
    localparam logic [2:0]  BURST_LAST    = 3'h7;
    localparam logic [2:0]  BEAT_CNT_RST  = 3'h0;
    localparam logic [4:0]  BEAT_STEP     = 5'h04;
    localparam logic [4:0]  BEAT_ADDR_RST = 5'h00;
    localparam logic [7:0]  CS_IDLE       = 8'hff;
    localparam logic [3:0]  HIT_BASE_RST  = 4'h0;
    localparam logic [31:0] ADDR_RST      = 32'h0000_0000;
endpackage : sbat_pkg

/* hw/sbat_tenure.sv */
// Address tenure engine of the system bus: owned tenures, external tenures, chip selects.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - External mode: drive owning master's address; decode addresses of external masters.
// - Internal mode: address lines serve only as memory address lines.
// - Master drives five transfer-type lines during tenure; slave samples them.
// - Simplified systems use only type bit one as read/write indicator.
// - Master drives four-bit size field; slave uses it to pick bytes.
// - Burst indicator marks a burst of exactly eight words; internal mode runs nine beats, the first ending the address phase.
// - Global flag driven on own tenures, set only for snooped transfers.
// - Eight chip selects, each enabling the device that an access targets.
// - Five burst-address outputs carry the low-order beat address to memory.
// - Transfer start marks the beginning of every new address tenure.
// - Slave acknowledges a recognised tenure; acknowledge ends the tenure.
module sbat_tenure (
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        ext_master_mode,
    input  wire logic        simple_rw_mode,
    input  wire logic [3:0]  hit_base,
    input  wire logic        req_valid,
    input  wire logic [31:0] req_addr,
    input  wire logic [4:0]  req_type,
    input  wire logic        req_write,
    input  wire logic [3:0]  req_size,
    input  wire logic        req_burst,
    input  wire logic        req_global,
    input  wire logic        data_beat,
    output logic             req_ready,
    output logic             req_done,
    input  wire logic [31:0] addr_in,
    output logic [31:0]      addr_out,
    output logic             addr_oe,
    input  wire logic        xfer_type_bit0_in,
    output logic             xfer_type_bit0_out,
    input  wire logic        xfer_type_bit1_rw_in,
    output logic             xfer_type_bit1_rw_out,
    input  wire logic [2:0]  xfer_type_upper_bits_in,
    output logic [2:0]       xfer_type_upper_bits_out,
    output logic             xfer_type_oe,
    input  wire logic [3:0]  xfer_size_field_in,
    output logic [3:0]       xfer_size_field_out,
    output logic             xfer_size_field_oe,
    input  wire logic        burst_indicator_in,
    output logic             burst_indicator_out,
    output logic             burst_indicator_oe,
    output logic             snoop_global_flag,
    input  wire logic        tenure_start_in,
    output logic             tenure_start_out,
    output logic             tenure_start_oe,
    input  wire logic        address_tenure_ack_in,
    output logic             address_tenure_ack_out,
    output logic             address_tenure_ack_oe,
    output logic [7:0]       chip_select_n,
    output logic             beat_address_bit27,
    output logic             beat_address_bit28,
    output logic             beat_address_bit29,
    output logic             beat_address_bit30,
    output logic             beat_address_bit31,
    output logic             ext_hit,
    output logic             ext_write,
    output logic [4:0]       ext_type,
    output logic [3:0]       ext_size,
    output logic             ext_burst,
    output logic [31:0]      ext_addr
);
    typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_BURST, ST_EXT} sbat_state_t;

    sbat_state_t                   state;
    logic [sbat_pkg::PIN_W-1:0]    pins_sync;
    logic [31:0]                   s_addr;
    logic [4:0]                    s_type;
    logic [3:0]                    s_size;
    logic                          s_burst;
    logic                          s_ts;
    logic                          s_address_tenure_ack;
    logic                          ts_prev;
    logic                          address_tenure_ack_prev;
    logic                          ts_rise;
    logic                          address_tenure_ack_rise;
    logic                          own_burst;
    logic [2:0]                    beat_count;
    logic [4:0]                    beat_addr;
    logic                          start_own;
    logic                          start_ext;
    logic                          own_end;

    // =========================================================================
    // Pin sampling
    sbat_pin_sync #(
        .WIDTH   (sbat_pkg::PIN_W)
    ) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .pin     ({addr_in, xfer_type_bit0_in, xfer_type_bit1_rw_in, xfer_type_upper_bits_in,
                   xfer_size_field_in, burst_indicator_in, tenure_start_in,
                   address_tenure_ack_in}),
        .stable  (pins_sync)
    );

    assign {s_addr, s_type, s_size, s_burst, s_ts, s_address_tenure_ack} = pins_sync;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ts_prev   <= 1'b0;
            address_tenure_ack_prev <= 1'b0;
        end else begin
            ts_prev   <= s_ts;
            address_tenure_ack_prev <= s_address_tenure_ack;
        end
    end

    assign ts_rise   = s_ts && !ts_prev;
    assign address_tenure_ack_rise = s_address_tenure_ack && !address_tenure_ack_prev;

    // An external tenure takes precedence over a new request of our own.
    assign start_ext = (state == ST_IDLE) && ext_master_mode && ts_rise;
    assign start_own = (state == ST_IDLE) && req_valid && !start_ext;
    // External mode ends on acknowledge, internal mode on the memory's first beat.
    assign own_end   = (state == ST_ADDR) && (ext_master_mode ? address_tenure_ack_rise : data_beat);

    // =========================================================================
    // Tenure state machine
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state      <= ST_IDLE;
            own_burst  <= 1'b0;
            beat_count <= sbat_pkg::BEAT_CNT_RST;
            req_ready  <= 1'b0;
            req_done   <= 1'b0;
        end else begin
            req_done  <= 1'b0;
            req_ready <= (state == ST_IDLE) && !start_own && !start_ext;
            unique case (state)
                ST_IDLE: begin
                    if (start_ext) begin
                        state <= ST_EXT;
                    end else if (start_own) begin
                        state     <= ST_ADDR;
                        own_burst <= req_burst;
                    end
                end
                ST_ADDR: begin
                    if (own_end) begin
                        beat_count <= sbat_pkg::BEAT_CNT_RST;
                        if (own_burst) begin
                            state <= ST_BURST;
                        end else begin
                            state    <= ST_IDLE;
                            req_done <= 1'b1;
                        end
                    end
                end
                ST_BURST: begin
                    if (data_beat) begin
                        beat_count <= beat_count + 3'h1;
                        if (beat_count == sbat_pkg::BURST_LAST) begin
                            state    <= ST_IDLE;
                            req_done <= 1'b1;
                        end
                    end
                end
                ST_EXT: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // =========================================================================
    // Address phase drive for own tenures
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            addr_out                 <= sbat_pkg::ADDR_RST;
            addr_oe                  <= 1'b0;
            xfer_type_bit0_out       <= 1'b0;
            xfer_type_bit1_rw_out    <= 1'b0;
            xfer_type_upper_bits_out <= 3'h0;
            xfer_type_oe             <= 1'b0;
            xfer_size_field_out      <= 4'h0;
            xfer_size_field_oe       <= 1'b0;
            burst_indicator_out      <= 1'b0;
            burst_indicator_oe       <= 1'b0;
            snoop_global_flag        <= 1'b0;
            tenure_start_out         <= 1'b0;
            tenure_start_oe          <= 1'b0;
            chip_select_n            <= sbat_pkg::CS_IDLE;
        end else begin
            tenure_start_out <= start_own && ext_master_mode;
            if (start_own) begin
                addr_out <= req_addr;
                addr_oe  <= 1'b1;
                chip_select_n <= ~(8'h01 << req_addr[sbat_pkg::CS_SEL_LSB +: sbat_pkg::CS_SEL_W]);
                xfer_type_oe       <= ext_master_mode;
                xfer_size_field_oe <= ext_master_mode;
                burst_indicator_oe <= ext_master_mode;
                tenure_start_oe    <= ext_master_mode;
                xfer_size_field_out <= req_size;
                burst_indicator_out <= req_burst;
                snoop_global_flag   <= ext_master_mode && req_global;
                if (simple_rw_mode) begin
                    {xfer_type_bit0_out, xfer_type_upper_bits_out} <= 4'h0;
                    xfer_type_bit1_rw_out <= req_write;
                end else begin
                    {xfer_type_bit0_out, xfer_type_bit1_rw_out, xfer_type_upper_bits_out}
                        <= req_type;
                end
            end else if (own_end) begin
                xfer_type_oe       <= 1'b0;
                xfer_size_field_oe <= 1'b0;
                burst_indicator_oe <= 1'b0;
                tenure_start_oe    <= 1'b0;
                snoop_global_flag  <= 1'b0;
                if (!own_burst) begin
                    addr_oe       <= 1'b0;
                    chip_select_n <= sbat_pkg::CS_IDLE;
                end
            end else if (req_done) begin
                addr_oe       <= 1'b0;
                chip_select_n <= sbat_pkg::CS_IDLE;
            end
        end
    end

    // =========================================================================
    // Burst beat address
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            beat_addr <= sbat_pkg::BEAT_ADDR_RST;
        end else if (start_own) begin
            beat_addr <= req_addr[sbat_pkg::BEAT_W-1:0];
        end else if (state == ST_BURST && data_beat && beat_count != sbat_pkg::BURST_LAST) begin
            beat_addr <= beat_addr + sbat_pkg::BEAT_STEP;
        end
    end

    assign beat_address_bit31 = beat_addr[0];
    assign beat_address_bit30 = beat_addr[1];
    assign beat_address_bit29 = beat_addr[2];
    assign beat_address_bit28 = beat_addr[3];
    assign beat_address_bit27 = beat_addr[4];

    // =========================================================================
    // Response to external tenures
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            address_tenure_ack_out <= 1'b0;
            address_tenure_ack_oe  <= 1'b0;
            ext_hit                <= 1'b0;
            ext_write              <= 1'b0;
            ext_type               <= 5'h00;
            ext_size               <= 4'h0;
            ext_burst              <= 1'b0;
            ext_addr               <= sbat_pkg::ADDR_RST;
        end else begin
            ext_hit <= start_ext && (s_addr[31:28] == hit_base);
            address_tenure_ack_out <= start_ext && (s_addr[31:28] == hit_base);
            address_tenure_ack_oe  <= start_ext && (s_addr[31:28] == hit_base);
            if (start_ext) begin
                ext_addr  <= s_addr;
                ext_type  <= s_type;
                ext_write <= s_type[3];
                ext_size  <= s_size;
                ext_burst <= s_burst;
            end
        end
    end

    // =========================================================================
    // Checks
    a_start_pulse_once: assert property (@(posedge clock) disable iff (!reset_n)
        tenure_start_out |=> !tenure_start_out) else $error("start held too long");
    a_owner_address: assert property (@(posedge clock) disable iff (!reset_n)
        tenure_start_out |-> addr_oe && addr_out == $past(req_addr)) else $error("bad address");
    a_global_snoop: assert property (@(posedge clock) disable iff (!reset_n)
        tenure_start_out |-> snoop_global_flag == $past(req_global)) else $error("bad global");
    a_simple_rw_bit: assert property (@(posedge clock) disable iff (!reset_n)
        tenure_start_out && $past(simple_rw_mode) |-> xfer_type_bit1_rw_out == $past(req_write))
        else $error("bad rw bit");
    a_type_driven: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(state == ST_ADDR) |-> addr_oe && xfer_type_oe == $past(ext_master_mode))
        else $error("type not driven");
    a_cs_one_hot: assert property (@(posedge clock) disable iff (!reset_n)
        chip_select_n != sbat_pkg::CS_IDLE |-> $onehot(~chip_select_n)) else $error("cs not one-hot");
    a_ack_ends_tenure: assert property (@(posedge clock) disable iff (!reset_n)
        state == ST_ADDR && ext_master_mode && address_tenure_ack_rise |=> state != ST_ADDR)
        else $error("ack ignored");
    a_burst_eight_beats: assert property (@(posedge clock) disable iff (!reset_n)
        state == ST_BURST && data_beat && beat_count == sbat_pkg::BURST_LAST
        |=> state == ST_IDLE && req_done) else $error("burst length wrong");
    a_beat_advance: assert property (@(posedge clock) disable iff (!reset_n)
        state == ST_BURST && data_beat && beat_count != sbat_pkg::BURST_LAST
        |=> beat_addr == $past(beat_addr) + sbat_pkg::BEAT_STEP) else $error("beat not advanced");
    a_ext_ack_hit: assert property (@(posedge clock) disable iff (!reset_n)
        ext_hit |-> address_tenure_ack_out && address_tenure_ack_oe ##1 !address_tenure_ack_out)
        else $error("ack shape wrong");
endmodule : sbat_tenure
`default_nettype wire

/* sim/sbat_bus_partner.sv */
// Far-side model: an external slave that acknowledges tenures and a memory that moves data.
`timescale 1ns/1ps
`default_nettype none
module sbat_bus_partner (
    input  wire logic       clock,
    input  wire logic       reset_n,
    input  wire logic       slow,
    input  wire logic       tenure_start_out,
    input  wire logic       xfer_type_oe,
    input  wire logic [7:0] chip_select_n,
    output logic            address_tenure_ack_in,
    output logic            data_beat
);
    logic [3:0] wait_cnt;
    logic       pending;
    // ==================================================================
    // Address acknowledge
    // ==================================================================
    // The acknowledge is held until the tenure outputs drop, since the pin is filtered.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pending               <= 1'h0;
            wait_cnt              <= 4'h0;
            address_tenure_ack_in <= 1'h0;
        end else if (tenure_start_out) begin
            pending  <= 1'h1;
            wait_cnt <= slow ? 4'h6 : 4'h1;
        end else if (pending && wait_cnt != 4'h0) begin
            wait_cnt <= wait_cnt - 4'h1;
        end else if (pending) begin
            pending               <= 1'h0;
            address_tenure_ack_in <= 1'h1;
        end else if (address_tenure_ack_in && !xfer_type_oe) begin
            address_tenure_ack_in <= 1'h0;
        end
    end
    // ==================================================================
    // Data beats
    // ==================================================================
    // One beat every other cycle while selected and the transfer-type outputs are not enabled.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            data_beat <= 1'h0;
        end else begin
            data_beat <= !data_beat && chip_select_n != sbat_pkg::CS_IDLE && !xfer_type_oe;
        end
    end
endmodule : sbat_bus_partner
`default_nettype wire

/* sim/tb_top.sv */
// Self-checking bench for the system bus address tenure engine.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    typedef struct packed {
        logic ext; logic simple; logic slow; logic [31:0] addr; logic [4:0] typ; logic wr;
        logic [3:0] size; logic burst; logic glob; logic [7:0] beats; logic [7:0] adv;
    } sbat_row_t;
    logic clock, reset_n, ext_master_mode, simple_rw_mode, req_valid, req_write, req_burst;
    logic req_global, data_beat, req_ready, req_done, addr_oe, slow, snoop_global_flag;
    logic xfer_type_bit0_in, xfer_type_bit0_out, xfer_type_bit1_rw_in, xfer_type_bit1_rw_out;
    logic xfer_type_oe, xfer_size_field_oe, burst_indicator_in, burst_indicator_out;
    logic burst_indicator_oe, tenure_start_in, tenure_start_out, tenure_start_oe;
    logic address_tenure_ack_in, address_tenure_ack_out, address_tenure_ack_oe;
    logic beat_address_bit27, beat_address_bit28, beat_address_bit29, beat_address_bit30;
    logic beat_address_bit31, ext_hit, ext_write, ext_burst;
    logic [2:0]  xfer_type_upper_bits_in, xfer_type_upper_bits_out;
    logic [3:0]  hit_base, req_size, xfer_size_field_in, xfer_size_field_out, ext_size;
    logic [4:0]  req_type, ext_type;
    logic [7:0]  chip_select_n;
    logic [31:0] req_addr, addr_in, addr_out, ext_addr;
    int          mismatches;
    int          total_checks;
    int          cycles;
    sbat_row_t   rows [6] = '{
        '{1'h1, 1'h0, 1'h0, 32'h0000_0010, 5'h0a, 1'h0, 4'h4, 1'h0, 1'h1, 8'h00, 8'h00},
        '{1'h1, 1'h0, 1'h1, 32'he000_001c, 5'h12, 1'h1, 4'h0, 1'h1, 1'h0, 8'h08, 8'h07},
        '{1'h1, 1'h1, 1'h0, 32'h4000_0004, 5'h00, 1'h1, 4'h1, 1'h0, 1'h1, 8'h00, 8'h00},
        '{1'h0, 1'h0, 1'h0, 32'h2000_0008, 5'h1f, 1'h0, 4'h8, 1'h0, 1'h1, 8'h01, 8'h00},
        '{1'h0, 1'h0, 1'h0, 32'ha000_0000, 5'h05, 1'h1, 4'h0, 1'h1, 1'h0, 8'h09, 8'h07},
        '{1'h1, 1'h0, 1'h0, 32'h6000_0003, 5'h0c, 1'h0, 4'h2, 1'h1, 1'h1, 8'h08, 8'h07}};

    sbat_tenure      i_sbat_tenure (.*);
    sbat_bus_partner i_sbat_bus_partner (.*);

    always #50 clock = ~clock;

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic stop_test();
        if (mismatches == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic tick();
        @(posedge clock);
        #1;
    endtask : tick

    function automatic logic [4:0] beat_addr();
        return {beat_address_bit27, beat_address_bit28, beat_address_bit29,
                beat_address_bit30, beat_address_bit31};
    endfunction : beat_addr

    // Issues one own request and follows it through to completion.
    task automatic run_row(input sbat_row_t r);
        int         n;
        int         beats;
        int         adv;
        logic [4:0] prev;
        n = 0;
        beats = 0;
        adv = 0;
        {ext_master_mode, simple_rw_mode, slow} = {r.ext, r.simple, r.slow};
        {req_addr, req_type, req_write, req_size} = {r.addr, r.typ, r.wr, r.size};
        {req_burst, req_global} = {r.burst, r.glob};
        while (req_ready !== 1'h1 && n < 50) begin
            tick();
            n++;
        end
        req_valid = 1'h1;
        tick();
        req_valid = 1'h0;
        chk(chip_select_n, 8'(~(8'h01 << r.addr[31:29])));
        chk(addr_out, r.addr);
        chk(snoop_global_flag, r.glob & r.ext);
        chk(beat_addr(), r.addr[4:0]);
        if (r.ext) begin
            chk({tenure_start_out, addr_oe, xfer_size_field_out, burst_indicator_out},
                {2'h3, r.size, r.burst});
            chk({xfer_type_oe, xfer_size_field_oe, burst_indicator_oe, tenure_start_oe},
                4'hf);
            if (r.simple) chk(xfer_type_bit1_rw_out, r.wr);
            else chk({xfer_type_bit0_out, xfer_type_bit1_rw_out, xfer_type_upper_bits_out},
                     r.typ);
        end else begin
            chk({tenure_start_oe, xfer_type_oe, xfer_size_field_oe, burst_indicator_oe},
                4'h0);
        end
        prev = beat_addr();
        n = 0;
        do begin
            if (n == 1 && r.ext) chk(tenure_start_out, 1'h0);
            if (data_beat === 1'h1) beats++;
            if (beat_addr() !== prev) begin
                adv++;
                chk(beat_addr(), 5'(prev + 5'h04));
                prev = beat_addr();
            end
            tick();
            n++;
        end while (req_done !== 1'h1 && n < 300);
        chk(req_done, 1'h1);
        chk(beats, r.beats);
        if (r.adv != 8'hff) chk(adv, r.adv);
        tick();
        chk(chip_select_n, sbat_pkg::CS_IDLE);
        chk(req_ready, 1'h1);
    endtask : run_row

    // An external master starts a tenure; released address, type and burst pins then show inverted values.
    task automatic ext_ten(input logic [31:0] a, input logic [4:0] t, input logic [3:0] base,
                           input logic hit);
        int   n;
        logic seen;
        seen = 1'h0;
        {ext_master_mode, hit_base, addr_in, xfer_size_field_in} = {1'h1, base, a, a[3:0]};
        {xfer_type_bit0_in, xfer_type_bit1_rw_in, xfer_type_upper_bits_in} = t;
        {burst_indicator_in, tenure_start_in} = {t[0], 1'h1};
        for (n = 0; n < 12; n++) begin
            tick();
            if (ext_hit === 1'h1) begin
                seen = 1'h1;
                chk({address_tenure_ack_out, address_tenure_ack_oe}, 2'h3);
                chk(ext_addr, a);
                chk({ext_type, ext_size, ext_burst}, {t, a[3:0], t[0]});
                chk(ext_write, t[3]);
            end
        end
        chk(seen, hit);
        {tenure_start_in, addr_in, burst_indicator_in} = {1'h0, ~a, ~t[0]};
        {xfer_type_bit0_in, xfer_type_bit1_rw_in, xfer_type_upper_bits_in} = ~t;
        repeat (6) tick();
    endtask : ext_ten

    initial begin
        {clock, reset_n, ext_master_mode, simple_rw_mode, req_valid, slow} = 6'h00;
        {req_write, req_burst, req_global, tenure_start_in, burst_indicator_in} = 5'h00;
        {xfer_type_bit0_in, xfer_type_bit1_rw_in, xfer_type_upper_bits_in} = 5'h00;
        {hit_base, req_size, xfer_size_field_in, req_type} = 17'h0_0000;
        {req_addr, addr_in} = 64'h0000_0000_0000_0000;
        {mismatches, total_checks, cycles} = {32'h0, 32'h0, 32'h0};
        repeat (2) @(posedge clock);
        #1;
        reset_n = 1'h1;
        repeat (2) tick();
        foreach (rows[i]) run_row(rows[i]);
        ext_ten(32'h3000_0125, 5'h0b, 4'h3, 1'h1);
        ext_ten(32'h9000_0040, 5'h14, 4'h9, 1'h1);
        ext_ten(32'h5000_0000, 5'h0b, 4'h3, 1'h0);
        {req_addr, req_burst, ext_master_mode, req_valid} = {32'hc000_0000, 1'h1, 1'h1, 1'h1};
        repeat (2) tick();
        req_valid = 1'h0;
        reset_n = 1'h0;
        #5;
        chk(chip_select_n, sbat_pkg::CS_IDLE);
        chk({addr_oe, tenure_start_out, req_done}, 3'h0);
        tick();
        reset_n = 1'h1;
        repeat (2) tick();
        run_row(rows[1]);
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
